// File: effort_shaper.sv
`timescale 1ns/10ps
module effort_shaper
  import lim_pkg::*;
(
  input  wire lim_pkg::val_t              raw,
  input  wire lim_pkg::val_t              fwd_low,
  input  wire lim_pkg::val_t              fwd_high,
  input  wire lim_pkg::val_t              bwd_low,
  input  wire lim_pkg::val_t              bwd_high,
  output logic signed [lim_pkg::EFF_W-1:0] shaped
);
  // full-width signed work value
  val_t v;
  // deadband and saturation per direction, then range clamp
  always_comb begin
    v = raw;
    if (raw > ZERO) begin
      // forwards: brake below deadband, saturate above limit
      if (raw < fwd_low) v = ZERO;
      else if (raw > fwd_high) v = fwd_high;
    end else if (raw < ZERO) begin
      // backwards: brake inside deadband, saturate beyond limit
      if (raw > bwd_low) v = ZERO;
      else if (raw < bwd_high) v = bwd_high;
    end
    v = clamp(v, EFF_MIN, EFF_MAX);
    shaped = v[EFF_W-1:0];
  end
endmodule // effort_shaper

// File: feedback_limits.sv
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
// How it works
// - low position kept at or below high
// - high position kept at or above low
// - forward deadband between backward deadband and saturation
// - forward saturation between forward deadband and 255
// - backward deadband between backward saturation, forward deadband
// - backward saturation between -255 and backward deadband
// - small forward effort forced to zero
// - large forward effort saturated to limit
// - small backward effort forced to zero
// - large backward effort saturated to limit
// - write answered with parameter's resulting value
// - read returns stored parameter value
// - position bounds bound the controller target as of its last setpoint write
// - new setpoint clamped into position bounds
// - effort stays within -255 to 255
module feedback_limits
  import lim_pkg::*;
(
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire lim_pkg::addr_t             awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire lim_pkg::addr_t             araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire lim_pkg::val_t              effort_raw,
  output logic signed [lim_pkg::EFF_W-1:0] effort_out,
  output lim_pkg::val_t                   target_pos
);
  // limit parameters
  val_t pos_low_q;                // lowest allowed target
  val_t pos_high_q;               // highest allowed target
  val_t fwd_low_q;                // forward deadband
  val_t fwd_high_q;               // forward saturation
  val_t bwd_low_q;                // backward deadband
  val_t bwd_high_q;               // backward saturation
  val_t target_q;                 // clamped setpoint
  val_t result_q;                 // value after last write
  logic [1:0] status_q;           // accept / reject of last write
  // write channel capture
  addr_t       aw_addr_q;         // held write address
  logic [31:0] w_data_q;          // held write data
  logic [3:0]  w_strb_q;          // held byte strobes
  logic        aw_got_q;          // address taken
  logic        w_got_q;           // data taken
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  ch_state_e   wr_state_q;        // write channel state
  // read channel
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  ch_state_e   rd_state_q;        // read channel state
  // effort path
  logic signed [EFF_W-1:0] shaped;        // combinational shaper out
  logic signed [EFF_W-1:0] effort_q;      // registered effort
  // write evaluation
  logic wr_fire;                  // both halves held, act now
  val_t nv;                       // merged candidate value
  logic wr_hit;                   // address is mapped
  logic wr_ok;                    // candidate passes its check
  val_t rd_val;                   // read mux output
  logic rd_hit;                   // read address is mapped
  assign awready    = awready_q;
  assign wready     = wready_q;
  assign bvalid     = bvalid_q;
  assign bresp      = bresp_q;
  assign arready    = arready_q;
  assign rvalid     = rvalid_q;
  assign rdata      = rdata_q;
  assign rresp      = rresp_q;
  assign effort_out = effort_q;
  assign target_pos = target_q;
  assign wr_fire = aw_got_q && w_got_q && (wr_state_q == CH_IDLE);
  // write decode: candidate value and its acceptance check
  always_comb begin
    nv     = merge(ZERO, w_data_q, w_strb_q);
    wr_hit = 1'b1;
    wr_ok  = 1'b0;
    if (aw_addr_q == OFS_POS_LOW) begin
      nv    = merge(pos_low_q, w_data_q, w_strb_q);
      wr_ok = (nv <= pos_high_q);
    end else if (aw_addr_q == OFS_POS_HIGH) begin
      nv    = merge(pos_high_q, w_data_q, w_strb_q);
      wr_ok = (nv >= pos_low_q);
    end else if (aw_addr_q == OFS_FWD_LOW) begin
      nv    = merge(fwd_low_q, w_data_q, w_strb_q);
      wr_ok = (nv <= fwd_high_q) && (nv >= bwd_low_q);
    end else if (aw_addr_q == OFS_FWD_HIGH) begin
      nv    = merge(fwd_high_q, w_data_q, w_strb_q);
      wr_ok = (nv >= fwd_low_q) && (nv <= EFF_MAX);
    end else if (aw_addr_q == OFS_BWD_LOW) begin
      nv    = merge(bwd_low_q, w_data_q, w_strb_q);
      wr_ok = (nv >= bwd_high_q) && (nv <= fwd_low_q);
    end else if (aw_addr_q == OFS_BWD_HIGH) begin
      nv    = merge(bwd_high_q, w_data_q, w_strb_q);
      wr_ok = (nv <= bwd_low_q) && (nv >= EFF_MIN);
    end else if (aw_addr_q == OFS_SETPOINT) begin
      nv    = merge(target_q, w_data_q, w_strb_q);
      wr_ok = 1'b1;
    end else if (aw_addr_q == OFS_EFFORT || aw_addr_q == OFS_RESULT ||
                 aw_addr_q == OFS_STATUS) begin
      wr_ok = 1'b0;               // read-only, write ignored
    end else begin
      wr_hit = 1'b0;              // unmapped
    end
  end
  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_got_q  <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;          // hold until response taken
      aw_got_q  <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (bvalid_q && bready) begin
      aw_got_q  <= 1'b0;
    end else if (!aw_got_q && wr_state_q == CH_IDLE) begin
      awready_q <= 1'b1;
    end
  end
  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (bvalid_q && bready) begin
      w_got_q  <= 1'b0;
    end else if (!w_got_q && wr_state_q == CH_IDLE) begin
      wready_q <= 1'b1;
    end
  end
  // write response state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= CH_IDLE;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
    end else begin
      case (wr_state_q)
        CH_IDLE: begin
          if (wr_fire) begin
            wr_state_q <= CH_RESP;
            bvalid_q   <= 1'b1;
            bresp_q    <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        CH_RESP: begin
          if (bready) begin
            wr_state_q <= CH_IDLE;
            bvalid_q   <= 1'b0;
          end
        end
        default: begin
          wr_state_q <= CH_IDLE;
          bvalid_q   <= 1'b0;
        end
      endcase
    end
  end
  // limit registers, updated only when the check passes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_low_q  <= RST_POS_LOW;
      pos_high_q <= RST_POS_HIGH;
      fwd_low_q  <= RST_FWD_LOW;
      fwd_high_q <= RST_FWD_HIGH;
      bwd_low_q  <= RST_BWD_LOW;
      bwd_high_q <= RST_BWD_HIGH;
    end else if (wr_fire && wr_ok) begin
      if (aw_addr_q == OFS_POS_LOW) pos_low_q <= nv;
      else if (aw_addr_q == OFS_POS_HIGH) pos_high_q <= nv;
      else if (aw_addr_q == OFS_FWD_LOW) fwd_low_q <= nv;
      else if (aw_addr_q == OFS_FWD_HIGH) fwd_high_q <= nv;
      else if (aw_addr_q == OFS_BWD_LOW) bwd_low_q <= nv;
      else if (aw_addr_q == OFS_BWD_HIGH) bwd_high_q <= nv;
    end
  end
  // controller target, clamped into the position window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_q <= RST_POS_LOW;
    end else if (wr_fire && aw_addr_q == OFS_SETPOINT) begin
      target_q <= clamp(nv, pos_low_q, pos_high_q);
    end
  end
  // resulting value and outcome of the last write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= ZERO;
      status_q <= '0;
    end else if (wr_fire && wr_hit) begin
      if (aw_addr_q == OFS_SETPOINT)
        result_q <= clamp(nv, pos_low_q, pos_high_q);
      else if (wr_ok)
        result_q <= nv;
      else
        result_q <= rd_old(aw_addr_q);
      status_q[ST_ACCEPT] <= wr_ok;
      status_q[ST_REJECT] <= !wr_ok;
    end
  end
  // stored value at a write address, for the rejected case
  function automatic val_t rd_old(input addr_t a);
    if (a == OFS_POS_LOW) return pos_low_q;
    else if (a == OFS_POS_HIGH) return pos_high_q;
    else if (a == OFS_FWD_LOW) return fwd_low_q;
    else if (a == OFS_FWD_HIGH) return fwd_high_q;
    else if (a == OFS_BWD_LOW) return bwd_low_q;
    else if (a == OFS_BWD_HIGH) return bwd_high_q;
    else if (a == OFS_SETPOINT) return target_q;
    else return ZERO;
  endfunction
  // read mux over all mapped registers
  always_comb begin
    rd_hit = 1'b1;
    rd_val = rd_old(araddr);
    if (araddr == OFS_EFFORT)
      rd_val = val_t'(effort_q);
    else if (araddr == OFS_RESULT)
      rd_val = result_q;
    else if (araddr == OFS_STATUS)
      rd_val = {30'h00000000, status_q};
    else if (araddr > OFS_STATUS || araddr[1:0] != 2'h0)
      rd_hit = 1'b0;              // unmapped or unaligned
  end
  // read channel state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= CH_IDLE;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= '0;
      rresp_q    <= RESP_OKAY;
    end else begin
      case (rd_state_q)
        CH_IDLE: begin
          if (arvalid && arready_q) begin
            rd_state_q <= CH_RESP;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b1;
            rdata_q    <= rd_hit ? rd_val : ZERO;
            rresp_q    <= rd_hit ? RESP_OKAY : RESP_SLVERR;
          end else begin
            arready_q  <= 1'b1;
          end
        end
        CH_RESP: begin
          if (rready) begin
            rd_state_q <= CH_IDLE;
            rvalid_q   <= 1'b0;
          end
        end
        default: begin
          rd_state_q <= CH_IDLE;
          rvalid_q   <= 1'b0;
        end
      endcase
    end
  end
  // effort deadband and saturation
  effort_shaper effort_shaper_inst (
    .raw      (effort_raw),
    .fwd_low  (fwd_low_q),
    .fwd_high (fwd_high_q),
    .bwd_low  (bwd_low_q),
    .bwd_high (bwd_high_q),
    .shaped   (shaped)
  );
  // registered effort output
  always_ff @(posedge aclk) begin
    if (!aresetn) effort_q <= '0;
    else effort_q <= shaped;
  end
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pos_order: assert property (pos_low_q <= pos_high_q)
    else $error("position bounds out of order");
  a_reject_high: assert property (
    wr_fire && aw_addr_q == OFS_POS_HIGH && nv < pos_low_q
    |=> $stable(pos_high_q))
    else $error("bad upper bound stored");
  a_eff_chain: assert property (
    bwd_high_q <= bwd_low_q && bwd_low_q <= fwd_low_q
    && fwd_low_q <= fwd_high_q)
    else $error("effort limits out of order");
  a_eff_span: assert property (
    fwd_high_q <= EFF_MAX && bwd_high_q >= EFF_MIN)
    else $error("effort limit beyond range");
  a_fwd_brake: assert property (
    effort_raw > ZERO && effort_raw < fwd_low_q |=> effort_q == '0)
    else $error("forward deadband not braking");
  a_fwd_sat: assert property (
    effort_raw > fwd_high_q && fwd_high_q > ZERO
    |=> val_t'(effort_q) == $past(fwd_high_q))
    else $error("forward saturation wrong");
  a_bwd_brake: assert property (
    effort_raw < ZERO && effort_raw > bwd_low_q |=> effort_q == '0)
    else $error("backward deadband not braking");
  a_bwd_sat: assert property (
    effort_raw < bwd_high_q && bwd_high_q < ZERO
    |=> val_t'(effort_q) == $past(bwd_high_q))
    else $error("backward saturation wrong");
  a_result_echo: assert property (
    wr_fire && aw_addr_q == OFS_FWD_LOW |=> result_q == fwd_low_q)
    else $error("result differs from stored value");
  a_read_value: assert property (
    arvalid && arready_q && araddr == OFS_POS_HIGH
    |=> rvalid_q && rdata_q == $past(pos_high_q))
    else $error("read data differs from stored");
  a_target_win: assert property (
    wr_fire && aw_addr_q == OFS_SETPOINT
    |=> target_q >= pos_low_q && target_q <= pos_high_q)
    else $error("target outside position window");
  a_bresp_once: assert property (
    bvalid_q && bready |=> !bvalid_q && !awready_q && !wready_q)
    else $error("write response repeated");
  c_reject: cover property (wr_fire && wr_hit && !wr_ok);
  c_accept: cover property (wr_fire && wr_ok);
  c_read: cover property (rvalid_q && rready);
  c_brake: cover property (effort_raw > ZERO && shaped == '0);
endmodule // feedback_limits

// File: host_model.sv
`timescale 1ns/10ps
// host side: names a parameter, writes it, reads it back
module host_model
  import lim_pkg::*;
(
  input  wire logic           aclk,
  output lim_pkg::addr_t      awaddr,
  output logic                awvalid,
  input  wire logic           awready,
  output logic [31:0]         wdata,
  output logic [3:0]          wstrb,
  output logic                wvalid,
  input  wire logic           wready,
  input  wire logic [1:0]     bresp,
  input  wire logic           bvalid,
  output logic                bready,
  output lim_pkg::addr_t      araddr,
  output logic                arvalid,
  input  wire logic           arready,
  input  wire logic [31:0]    rdata,
  input  wire logic [1:0]     rresp,
  input  wire logic           rvalid,
  output logic                rready
);
  // idle bus from time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata  = '0;
    wstrb  = 4'hF;
  end

  // one write; address and data offered together, released when taken
  task automatic write(input addr_t a, input logic [31:0] d,
                       output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      // released lines show the inverse, never the old value
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end
    while (!bvalid) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // one read; rready held until the answer is sampled
  task automatic read(input addr_t a, output logic [31:0] d,
                      output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr  <= ~a;
    while (!rvalid) @(posedge aclk);
    d    = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule // host_model

// File: lim_pkg.sv
package lim_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int EFF_W  = 9;
  typedef logic signed [31:0] val_t;
  typedef logic [ADDR_W-1:0]  addr_t;
  // register byte offsets
  localparam addr_t OFS_POS_LOW  = 8'h00;
  localparam addr_t OFS_POS_HIGH = 8'h04;
  localparam addr_t OFS_FWD_LOW  = 8'h08;
  localparam addr_t OFS_FWD_HIGH = 8'h0C;
  localparam addr_t OFS_BWD_LOW  = 8'h10;
  localparam addr_t OFS_BWD_HIGH = 8'h14;
  localparam addr_t OFS_SETPOINT = 8'h18;
  localparam addr_t OFS_EFFORT   = 8'h1C;
  localparam addr_t OFS_RESULT   = 8'h20;
  localparam addr_t OFS_STATUS   = 8'h24;
  // reset values, already mutually ordered
  localparam val_t RST_POS_LOW  = 32'h00000000;
  localparam val_t RST_POS_HIGH = 32'h000003FF;
  localparam val_t RST_FWD_LOW  = 32'h00000000;
  localparam val_t RST_FWD_HIGH = 32'h000000FF;
  localparam val_t RST_BWD_LOW  = 32'h00000000;
  localparam val_t RST_BWD_HIGH = 32'hFFFFFF01;
  localparam val_t ZERO         = 32'h00000000;
  // effort range, +255 and -255
  localparam val_t EFF_MAX = 32'h000000FF;
  localparam val_t EFF_MIN = 32'hFFFFFF01;
  // status bits
  localparam int ST_ACCEPT = 0;
  localparam int ST_REJECT = 1;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // one-hot channel states
  typedef enum logic [1:0] {
    CH_IDLE = 2'h1,
    CH_RESP = 2'h2
  } ch_state_e;
  // inclusive clamp of a signed value
  function automatic val_t clamp(input val_t v, input val_t lo,
                                 input val_t hi);
    if (v < lo) return lo;
    else if (v > hi) return hi;
    else return v;
  endfunction
  // byte-lane merge of write data onto an old word
  function automatic val_t merge(input val_t old, input logic [31:0] nw,
                                 input logic [3:0] strb);
    val_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction
endpackage

// File: tb_feedback_limit_params.sv
`timescale 1ns/10ps
// self-checking bench for the limit parameter block
module tb_feedback_limit_params;
  import lim_pkg::*;
  localparam int LIMIT = 5000;  // cycle ceiling
  localparam addr_t REGS[6] = '{OFS_POS_LOW, OFS_POS_HIGH, OFS_FWD_LOW,
                                OFS_FWD_HIGH, OFS_BWD_LOW, OFS_BWD_HIGH};
  localparam val_t RSTV[6] = '{RST_POS_LOW, RST_POS_HIGH, RST_FWD_LOW,
                               RST_FWD_HIGH, RST_BWD_LOW, RST_BWD_HIGH};
  logic                     aclk, aresetn;
  addr_t                    awaddr, araddr;
  logic                     awvalid, awready, wvalid, wready, bvalid;
  logic                     bready, arvalid, arready, rvalid, rready;
  logic [31:0]              wdata, rdata, d;
  logic [3:0]               wstrb;
  logic [1:0]               bresp, rresp, resp;
  val_t                     effort_raw, target_pos;
  logic signed [EFF_W-1:0]  effort_out;
  val_t                     m[6];  // bench copy of the six limits
  int                       bad_count = 0;
  int                       comparisons = 0;
  int                       cycles = 0;

  feedback_limits feedback_limits_inst (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .effort_raw(effort_raw), .effort_out(effort_out),
    .target_pos(target_pos));
  host_model host_model_inst (.aclk(aclk), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  // 20 MHz clock
  initial aclk = 1'b0;
  always #25 aclk = ~aclk;

  // hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // acceptance of a new limit value, signed compares
  function automatic bit ok(int i, val_t v);
    case (i)
      0: return v <= m[1];
      1: return v >= m[0];
      2: return v <= m[3] && v >= m[4];
      3: return v >= m[2] && v <= EFF_MAX;
      4: return v >= m[5] && v <= m[2];
      default: return v <= m[4] && v >= EFF_MIN;
    endcase
  endfunction

  // expected shaped effort from the stored limits
  function automatic val_t shape(val_t v);
    if (v > 0) return v < m[2] ? ZERO : (v > m[3] ? m[3] : v);
    if (v < 0) return v > m[4] ? ZERO : (v < m[5] ? m[5] : v);
    return ZERO;
  endfunction

  // all six limits read back at their reset values
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      m[i] = RSTV[i];
      host_model_inst.read(REGS[i], d, resp);
      check(d, m[i], "reset value");
    end
    $display("test reset done");
  endtask

  // writes across every limit, accepted and refused
  task automatic t_limits();
    localparam int WI[18] = '{0, 0, 1, 1, 1, 0, 3, 3, 2, 2, 2,
                              4, 4, 4, 5, 5, 5, 3};
    // kept forward limits nonnegative, backward negative
    localparam int WV[18] = '{2000, 20, 19, 20, 400, 401, 256, 200, 201,
                              40, -21, 41, -300, -20, -256, -19, -150, 39};
    bit   acc;
    val_t v;
    for (int k = 0; k < 18; k++) begin
      v   = val_t'(WV[k]);
      acc = ok(WI[k], v);
      if (acc) m[WI[k]] = v;
      host_model_inst.write(REGS[WI[k]], v, resp);
      check({30'h0, resp}, {30'h0, RESP_OKAY}, "write resp");
      host_model_inst.read(OFS_RESULT, d, resp);
      check(d, m[WI[k]], "resulting value");
      host_model_inst.read(OFS_STATUS, d, resp);
      check({30'h0, d[1:0]}, acc ? 32'h1 : 32'h2, "status");
      host_model_inst.read(REGS[WI[k]], d, resp);
      check(d, m[WI[k]], "stored limit");
    end
    $display("test limits done");
  endtask

  // setpoints clamped into the position bounds
  task automatic t_setpoint();
    localparam int SP[6] = '{5, 1000, 123, -7, 20, 400};
    val_t e;
    for (int k = 0; k < 6; k++) begin
      e = val_t'(SP[k]);
      e = e < m[0] ? m[0] : (e > m[1] ? m[1] : e);
      host_model_inst.write(OFS_SETPOINT, val_t'(SP[k]), resp);
      check(target_pos, e, "target");
      host_model_inst.read(OFS_SETPOINT, d, resp);
      check(d, e, "target read");
    end
    $display("test setpoint done");
  endtask

  // effort shaping, one cycle from input to output
  task automatic t_effort();
    localparam int EV[14] = '{10, 39, 40, 100, 200, 201, 300, -10, -19,
                              -20, -150, -151, -1000, 0};
    for (int k = 0; k < 14; k++) begin
      @(posedge aclk);
      effort_raw <= val_t'(EV[k]);
      @(posedge aclk);
      #1;
      check(32'(effort_out), shape(val_t'(EV[k])), "effort");
      host_model_inst.read(OFS_EFFORT, d, resp);
      check(d, shape(val_t'(EV[k])), "effort read");
    end
    $display("test effort done");
  endtask

  // read-only and unmapped places
  task automatic t_bus();
    host_model_inst.write(OFS_RESULT, 32'h0000_0055, resp);
    host_model_inst.read(OFS_STATUS, d, resp);
    check({30'h0, d[1:0]}, 32'h2, "ro write status");
    host_model_inst.write(8'h30, 32'h0000_0001, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    host_model_inst.read(8'h02, d, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR}, "unaligned read");
    check(d, ZERO, "unaligned data");
    $display("test bus done");
  endtask

  // main sequence, a second reset in mid-run at the end
  initial begin
    aresetn    = 1'b0;
    effort_raw = ZERO;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_limits();
    t_setpoint();
    t_effort();
    t_bus();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    conclude();
  end
endmodule // tb_feedback_limit_params
